//--- hw/lscu_top.sv
// Serial command front end of a character display controller
`include "lscu_regs.svh"

// Summary of operation
// - Line bit 0 selects one line at 1/9 duty, 1 two lines at 1/17.
// - Icon address loads 4-bit pointer, targets icon RAM, busy ten oscillator periods.
// - Character address loads 5-bit pointer and targets character code RAM.
// - Glyph address loads 6-bit pointer and targets glyph RAM.
// - Status word: wake key, busy, six rows, six columns, two zeros, MSB first.
// - Outside standby, each row and column bit reads 1 while a key on it is pressed.
// - Status read works while busy; held strobe repeats with fresh 16-bit words.
// - Lamp write carries three lamp bits, latched at the write strobe rising edge.
// - Lamp write executes even in standby or while busy.
// - RAM write stores low byte; glyph RAM keeps only five bits.
// - Data writes go to the RAM of the latest address instruction.
// - Each data write steps the pointer by one and pulses display shift when shift is enabled.
// - With write strobe held after a RAM write, later transfers are bytes.
// - Writes: strobe low, bits on the shift clock, strobe high, then wait.
// - Reads: strobe low loads data, rising shift edges clock bits out.
// - Both strobes low: standby, stop oscillator, blank, fill spaces, pointer zero.
// - Icon RAM cleared on standby only when the last instruction had bit 4 set.
// - Wake key low ends standby unless both strobes low; then runs oscillator.
// - Instruction register is write only; pointer steps after each data access.
// - While busy, only status read, lamp write, standby entry and standby clear are taken.
// - Standby clear starts the oscillator, display off, ignored outside standby.
// - Direction bit 1 increments, 0 decrements the pointer.
module lscu_top #(
  parameter int EXEC_CYC = `LSCU_EXEC_CYC,
  parameter int QDEPTH = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Serial link pins
  input wire logic sck_i,
  input wire logic rd_strobe_n_i,
  input wire logic wr_strobe_n_i,
  input wire logic serial_io_line_i,
  output logic serial_io_line_o,
  output logic serial_io_line_oe_n_o,
  // Key inputs, rows and columns high when pressed
  input wire logic wake_key_input_n_i,
  input wire logic key_down_n_i,
  input wire logic [5:0] key_row_bits_i,
  input wire logic [5:0] key_col_bits_i,
  // Display control
  output logic two_line_o,
  output logic standby_o,
  output logic osc_run_o,
  output logic busy_flag_o,
  output logic shift_pulse_o,
  output logic incr_dir_o,
  output logic [2:0] lamp_bits_o,
  // Display RAM write port
  output logic ram_vld_o,
  input wire logic ram_rdy_i,
  output logic [1:0] ram_sel_o,
  output logic [5:0] ram_addr_o,
  output logic [7:0] ram_data_o
);
  typedef struct packed {
    lscu_pkg::lscu_state_t state;
    logic [15:0] cnt;
    logic [15:0] sh_in;
    logic [4:0] nbits;
    logic burst;
    logic [15:0] instr;
    logic [2:0] lamp_pend;
    logic lamp_arm;
    logic [2:0] lamp;
    logic two_line;
    logic locked;
    logic incr;
    logic shift_en;
    lscu_pkg::lscu_ram_t sel;
    logic [5:0] ptr;
    logic standby;
    logic osc;
    logic busy;
    lscu_pkg::lscu_wr_t wq;
    logic wq_vld;
    logic [4:0] fill_ptr;
    logic fill_icon;
    logic icon_clr;
    logic [15:0] rd_sh;
    logic [3:0] rd_cnt;
    logic sio;
    logic oe_n;
    logic shift_pulse;
  } lscu_st_t;

  lscu_st_t st_ff, nxt_st;
  lscu_link_if lk ();
  lscu_pkg::lscu_wr_t fo;
  logic f_rdy;
  logic word_done;
  logic do_ramw;
  logic both_low;
  logic [15:0] w;
  logic [15:0] stat;

  // Pointer stepping, used by data writes
  function automatic logic [5:0] step_ptr(input logic [5:0] p, input logic up);
    step_ptr = up ? p + 6'h01 : p - 6'h01;
  endfunction

  lscu_link u_link (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .sck_i(sck_i),
    .rd_n_i(rd_strobe_n_i),
    .wr_n_i(wr_strobe_n_i),
    .sio_i(serial_io_line_i),
    .wake_key_n_i(wake_key_input_n_i),
    .key_down_n_i(key_down_n_i),
    .key_row_i(key_row_bits_i),
    .key_col_i(key_col_bits_i),
    .lk_o(lk)
  );

  // Queue lets the display side stall writes; a full queue keeps busy high
  lscu_fifo #(
    .W($bits(lscu_pkg::lscu_wr_t)),
    .D(QDEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .in_vld_i(st_ff.wq_vld),
    .in_rdy_o(f_rdy),
    .in_data_i(st_ff.wq),
    .out_vld_o(ram_vld_o),
    .out_rdy_i(ram_rdy_i),
    .out_data_o(fo)
  );

  assign both_low = ~lk.rd_n & ~lk.wr_n;
  // Key rows and columns read zero in standby
  assign stat = {~lk.wake_n, st_ff.busy,
                 st_ff.standby ? 6'h00 : lk.row,
                 st_ff.standby ? 6'h00 : lk.col, 2'h0};

  // Whole next state in one place
  always_comb begin
    nxt_st = st_ff;
    nxt_st.shift_pulse = 1'b0;
    word_done = 1'b0;
    do_ramw = 1'b0;
    w = '0;
    if (st_ff.wq_vld && f_rdy) begin
      nxt_st.wq_vld = 1'b0;
    end

    // Readout; busy does not block it
    if (lk.rd_fall && lk.wr_n) begin
      nxt_st.rd_sh = stat;
      nxt_st.rd_cnt = '0;
      nxt_st.sio = stat[15];
      nxt_st.oe_n = 1'b0;
      nxt_st.locked = 1'b1;
    end else if (!lk.rd_n && lk.wr_n && lk.sck_rise) begin
      if (st_ff.rd_cnt == 4'hf) begin
        nxt_st.rd_sh = stat;
        nxt_st.sio = stat[15];
      end else begin
        nxt_st.rd_sh = {st_ff.rd_sh[14:0], 1'b0};
        nxt_st.sio = st_ff.rd_sh[14];
      end
      nxt_st.rd_cnt = st_ff.rd_cnt + 4'h1;
    end
    if (lk.rd_n || !lk.wr_n) begin
      nxt_st.oe_n = 1'b1;
    end

    // Shift in one bit per rising shift clock while writing
    if (!lk.wr_n && lk.rd_n && lk.sck_rise) begin
      nxt_st.sh_in = {st_ff.sh_in[14:0], lk.sdi};
      nxt_st.nbits = st_ff.nbits + 5'h01;
      if (st_ff.burst ? st_ff.nbits == 5'h07 : st_ff.nbits == 5'h0f) begin
        word_done = 1'b1;
        nxt_st.nbits = '0;
        w = st_ff.burst ? {`LSCU_RAMW_HDR, nxt_st.sh_in[7:0]} : nxt_st.sh_in;
      end
    end
    // Lamp bits land on the strobe rising edge
    if (lk.wr_rise) begin
      nxt_st.nbits = '0;
      nxt_st.burst = 1'b0;
      if (st_ff.lamp_arm) begin
        nxt_st.lamp = st_ff.lamp_pend;
        nxt_st.lamp_arm = 1'b0;
      end
    end

    // Leading-one decode
    if (word_done) begin
      nxt_st.instr = w;
      if (w[15:14] == 2'h2) begin
        nxt_st.lamp_pend = w[2:0];
        nxt_st.lamp_arm = 1'b1;
        nxt_st.locked = 1'b1;
      end else if (st_ff.standby) begin
        if (w == `LSCU_STBY_CLR) begin
          nxt_st.standby = 1'b0;
          nxt_st.locked = 1'b1;
        end
      end else if (!st_ff.busy) begin
        nxt_st.state = lscu_pkg::ST_EXEC;
        nxt_st.cnt = '0;
        if (w[15]) begin
          do_ramw = 1'b1;
          nxt_st.wq.sel = st_ff.sel;
          nxt_st.wq.addr = st_ff.ptr;
          nxt_st.wq.data = (st_ff.sel == lscu_pkg::RAM_GLYPH) ? {3'h0, w[4:0]} : w[7:0];
          nxt_st.wq_vld = 1'b1;
          nxt_st.ptr = step_ptr(st_ff.ptr, st_ff.incr);
          nxt_st.shift_pulse = st_ff.shift_en;
          nxt_st.burst = 1'b1;
        end else if (w[13]) begin
          nxt_st.sel = lscu_pkg::RAM_GLYPH;
          nxt_st.ptr = w[12:7];
        end else if (w[12]) begin
          nxt_st.sel = lscu_pkg::RAM_CHAR;
          nxt_st.ptr = {1'b0, w[11:7]};
        end else if (w[11]) begin
          nxt_st.sel = lscu_pkg::RAM_ICON;
          nxt_st.ptr = {2'h0, w[10:7]};
        end else if (w[10]) begin
          if (!st_ff.locked) begin
            nxt_st.two_line = w[`LSCU_LINE_BIT];
          end
        end else if (w[9:8] == 2'h0 && w[7]) begin
          nxt_st.incr = w[`LSCU_DIR_BIT];
          nxt_st.shift_en = w[`LSCU_SHIFT_BIT];
        end else begin
          nxt_st.state = lscu_pkg::ST_IDLE;
        end
      end
    end

    // Execution timer runs on the oscillator only; fill walks the RAMs
    unique case (st_ff.state)
      lscu_pkg::ST_IDLE: begin
      end
      lscu_pkg::ST_EXEC: begin
        if (st_ff.osc) begin
          nxt_st.cnt = st_ff.cnt + 16'h0001;
          if (st_ff.cnt == 16'(EXEC_CYC - 1)) begin
            nxt_st.state = lscu_pkg::ST_IDLE;
          end
        end
      end
      lscu_pkg::ST_FILL: begin
        if (!nxt_st.wq_vld) begin
          nxt_st.wq.sel = st_ff.fill_icon ? lscu_pkg::RAM_ICON : lscu_pkg::RAM_CHAR;
          nxt_st.wq.addr = {1'b0, st_ff.fill_ptr};
          nxt_st.wq.data = st_ff.fill_icon ? 8'h00 : `LSCU_SPACE;
          nxt_st.wq_vld = 1'b1;
          nxt_st.fill_ptr = st_ff.fill_ptr + 5'h01;
          if (st_ff.fill_ptr == (st_ff.fill_icon ? `LSCU_ICON_LAST : `LSCU_CHAR_LAST)) begin
            nxt_st.fill_ptr = '0;
            if (!st_ff.fill_icon && st_ff.icon_clr) begin
              nxt_st.fill_icon = 1'b1;
            end else begin
              nxt_st.state = lscu_pkg::ST_IDLE;
            end
          end
        end
      end
    endcase

    // Both strobes low enter standby
    if (both_low && !st_ff.standby) begin
      nxt_st.standby = 1'b1;
      nxt_st.state = lscu_pkg::ST_FILL;
      nxt_st.fill_ptr = '0;
      nxt_st.fill_icon = 1'b0;
      nxt_st.icon_clr = st_ff.instr[`LSCU_ICON_CLR_BIT];
      nxt_st.ptr = '0;
      nxt_st.burst = 1'b0;
      nxt_st.nbits = '0;
    end
    // Wake key ends standby unless both strobes are low
    if (st_ff.standby && !lk.wake_n && !both_low) begin
      nxt_st.standby = 1'b0;
    end
    nxt_st.osc = ~nxt_st.standby | ~lk.wake_n | ~lk.key_dn_n;
    nxt_st.busy = (nxt_st.state != lscu_pkg::ST_IDLE) | nxt_st.wq_vld;
  end

  // Device starts in standby with the oscillator stopped
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st_ff <= '0;
      st_ff.standby <= 1'b1;
      st_ff.incr <= 1'b1;
      st_ff.oe_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign serial_io_line_o = st_ff.sio;
  assign serial_io_line_oe_n_o = st_ff.oe_n;
  assign two_line_o = st_ff.two_line;
  assign standby_o = st_ff.standby;
  assign osc_run_o = st_ff.osc;
  assign busy_flag_o = st_ff.busy;
  assign shift_pulse_o = st_ff.shift_pulse;
  assign incr_dir_o = st_ff.incr;
  assign lamp_bits_o = st_ff.lamp;
  assign ram_sel_o = fo.sel;
  assign ram_addr_o = fo.addr;
  assign ram_data_o = fo.data;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_exec_start;
    st_ff.state == lscu_pkg::ST_IDLE ##1 st_ff.state == lscu_pkg::ST_EXEC;
  endsequence

  lamp_latch_a: assert property (
    lk.wr_rise && st_ff.lamp_arm |=> lamp_bits_o == $past(st_ff.lamp_pend))
    else $error("lamp bits not latched at strobe rise");
  line_lock_a: assert property (
    $changed(two_line_o) |-> !$past(st_ff.locked) && st_ff.instr[15:10] == 6'h01)
    else $error("line mode changed when not allowed");
  ptr_step_a: assert property (
    do_ramw |=> st_ff.ptr == ($past(st_ff.incr) ? $past(st_ff.ptr) + 6'h01
                                               : $past(st_ff.ptr) - 6'h01))
    else $error("pointer did not step after data write");
  glyph_trim_a: assert property (
    do_ramw && st_ff.sel == lscu_pkg::RAM_GLYPH |=> st_ff.wq.data[7:5] == 3'h0)
    else $error("glyph data upper bits kept");
  busy_hold_a: assert property (
    s_exec_start |-> (busy_flag_o && st_ff.state == lscu_pkg::ST_EXEC)[*8])
    else $error("execution ended too early");
  stby_entry_a: assert property (
    $rose(standby_o) |-> st_ff.ptr == 6'h00 && st_ff.state == lscu_pkg::ST_FILL)
    else $error("standby entry did not clear pointer or start fill");
  icon_choice_a: assert property (
    $rose(standby_o) |-> st_ff.icon_clr == $past(st_ff.instr[4]))
    else $error("icon clear choice wrong");
  status_msb_a: assert property (
    lk.rd_fall && lk.wr_n |=> serial_io_line_o == ~$past(lk.wake_n) && !serial_io_line_oe_n_o)
    else $error("status msb not wake key");
  wake_exit_a: assert property (
    standby_o && !lk.wake_n && !both_low |=> !standby_o ##1 osc_run_o)
    else $error("wake key did not end standby");
endmodule

//--- inc/lscu_regs.svh
// Timing counts, field positions and fill values of the serial command unit
`ifndef LSCU_REGS_SVH
`define LSCU_REGS_SVH
// Clock and oscillator rates in Hz
`define LSCU_CLK_HZ 50000000
`define LSCU_FOSC_HZ 70000
// Execution time of a timed instruction, in oscillator periods
`define LSCU_EXEC_OSC 10
// Same time in clock cycles, rounded up
`define LSCU_EXEC_CYC (((`LSCU_EXEC_OSC * `LSCU_CLK_HZ) + `LSCU_FOSC_HZ - 1) / `LSCU_FOSC_HZ)
// Instruction words and field positions
`define LSCU_STBY_CLR 16'h0001
`define LSCU_RAMW_HDR 8'hc0
`define LSCU_ICON_CLR_BIT 4
`define LSCU_LINE_BIT 9
`define LSCU_DIR_BIT 6
`define LSCU_SHIFT_BIT 5
// Standby fill: space code and last RAM addresses
`define LSCU_SPACE 8'h20
`define LSCU_CHAR_LAST 5'h13
`define LSCU_ICON_LAST 5'h09
// Reset value of the synchronised pins {sck,rd_n,wr_n,sio,wake_n,key_dn_n,row,col}
`define LSCU_SYNC_RST 18'h1f000
`endif

//--- inc/lscu_pkg.sv
// Types shared by the serial command unit modules
package lscu_pkg;
  // Command engine states, Gray coded
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_EXEC = 2'h1,
    ST_FILL = 2'h3
  } lscu_state_t;
  // Target RAM of data writes
  typedef enum logic [1:0] {
    RAM_CHAR = 2'h0,
    RAM_GLYPH = 2'h1,
    RAM_ICON = 2'h2
  } lscu_ram_t;
  // One queued RAM write
  typedef struct packed {
    lscu_ram_t sel;
    logic [5:0] addr;
    logic [7:0] data;
  } lscu_wr_t;
endpackage

//--- inc/lscu_link_if.sv
// Synchronised link and key signals between the pin stage and the core
interface lscu_link_if;
  logic sck_rise;
  logic rd_n;
  logic rd_fall;
  logic wr_n;
  logic wr_rise;
  logic sdi;
  logic wake_n;
  logic key_dn_n;
  logic [5:0] row;
  logic [5:0] col;
  modport drv (output sck_rise, rd_n, rd_fall, wr_n, wr_rise, sdi, wake_n, key_dn_n, row, col);
  modport core (input sck_rise, rd_n, rd_fall, wr_n, wr_rise, sdi, wake_n, key_dn_n, row, col);
endinterface

//--- hw/lscu_link.sv
// Pin synchronisers and edge detection for the serial link
`include "lscu_regs.svh"

module lscu_link (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Pins from the host and keypad
  input wire logic sck_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic sio_i,
  input wire logic wake_key_n_i,
  input wire logic key_down_n_i,
  input wire logic [5:0] key_row_i,
  input wire logic [5:0] key_col_i,
  // Synchronised view
  lscu_link_if.drv lk_o
);
  typedef struct packed {
    logic [17:0] s1;
    logic [17:0] s2;
    logic [17:0] s3;
  } lscu_sync_t;
  lscu_sync_t st_ff, nxt_st;

  // Two flops per pin, a third only for edge finding
  always_comb begin
    nxt_st.s1 = {sck_i, rd_n_i, wr_n_i, sio_i, wake_key_n_i, key_down_n_i, key_row_i, key_col_i};
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st_ff <= {3{`LSCU_SYNC_RST}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Edges come from the second and third flops only
  assign lk_o.sck_rise = st_ff.s2[17] & ~st_ff.s3[17];
  assign lk_o.rd_n = st_ff.s2[16];
  assign lk_o.rd_fall = ~st_ff.s2[16] & st_ff.s3[16];
  assign lk_o.wr_n = st_ff.s2[15];
  assign lk_o.wr_rise = st_ff.s2[15] & ~st_ff.s3[15];
  assign lk_o.sdi = st_ff.s2[14];
  assign lk_o.wake_n = st_ff.s2[13];
  assign lk_o.key_dn_n = st_ff.s2[12];
  assign lk_o.row = st_ff.s2[11:6];
  assign lk_o.col = st_ff.s2[5:0];
endmodule

//--- hw/lscu_fifo.sv
// Write queue between the command engine and the display RAM port
module lscu_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Filling side
  input wire logic in_vld_i,
  output logic in_rdy_o,
  input wire logic [W-1:0] in_data_i,
  // Draining side, data from a register
  output logic out_vld_o,
  input wire logic out_rdy_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic ov;
    logic [W-1:0] od;
  } lscu_fifo_st_t;
  lscu_fifo_st_t st_ff, nxt_st;
  logic [W-1:0] mem_ff [D];
  logic push;
  logic pop;

  assign in_rdy_o = st_ff.cnt != (AW+1)'(D);
  assign push = in_vld_i & in_rdy_o;
  // Refill the output register whenever it is empty or being taken
  assign pop = (st_ff.cnt != '0) & (~st_ff.ov | out_rdy_i);

  // Pointer, count and output stage
  always_comb begin
    nxt_st = st_ff;
    nxt_st.wp = st_ff.wp + AW'(push);
    nxt_st.rp = st_ff.rp + AW'(pop);
    nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (pop) begin
      nxt_st.ov = 1'b1;
      nxt_st.od = mem_ff[st_ff.rp];
    end else if (out_rdy_i) begin
      nxt_st.ov = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Storage, no reset needed
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_ff[st_ff.wp] <= in_data_i;
    end
  end

  assign out_vld_o = st_ff.ov;
  assign out_data_o = st_ff.od;
endmodule

//--- verif/lscu_host.sv
// Host processor model that drives the serial strobes and shift clock
module lscu_host (
  // Bench clock used for pacing
  input wire logic clk_i,
  // Link pins
  output logic sck_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic sio_o,
  output logic sio_en_o,
  input wire logic sio_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // Host owns the data line only in write mode
  assign sio_en_o = ~wr_n_o;
  // Idle link: strobes high, shift clock low
  initial begin
    sck_o = 1'b0;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    sio_o = 1'b0;
  end
  // Half of the 160 ns shift clock period
  task automatic half();
    repeat (4) @(negedge clk_i);
  endtask
  // Bits MSB first, changed only while the shift clock is low
  task automatic shift(input logic [15:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      sio_o = w[i];
      half();
      sck_o = 1'b1;
      half();
      sck_o = 1'b0;
    end
  endtask
  // One instruction word; hold keeps the write strobe low for a burst
  task automatic wr_word(input logic [15:0] w, input logic hold);
    wr_n_o = 1'b0;
    half();
    shift(w, 16);
    half();
    if (!hold) begin
      wr_n_o = 1'b1;
      half();
    end
  endtask
  // Further data byte of a burst
  task automatic wr_byte(input logic [7:0] b);
    shift({8'h00, b}, 8);
    half();
  endtask
  // Ends a burst
  task automatic wr_end();
    wr_n_o = 1'b1;
    half();
  endtask
  // Sample before each rise, since the rise moves the next bit out
  task automatic rd_words(input int n, output logic [31:0] q);
    q = 32'h0;
    rd_n_o = 1'b0;
    half();
    half();
    for (int i = 0; i < 16 * n; i++) begin
      q = {q[30:0], sio_i};
      sck_o = 1'b1;
      half();
      sck_o = 1'b0;
      half();
    end
    rd_n_o = 1'b1;
    half();
  endtask
  // Both strobes low; read strobe released first so no read is started
  task automatic standby(input int cyc);
    wr_n_o = 1'b0;
    rd_n_o = 1'b0;
    repeat (cyc) @(negedge clk_i);
    rd_n_o = 1'b1;
    half();
    wr_n_o = 1'b1;
    half();
  endtask
endmodule

//--- verif/tb_top.sv
// Self-checking bench of the serial command unit
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Short execution count keeps the run brief
  localparam int EXEC = 400;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic wake_n = 1'b1;
  logic key_dn_n = 1'b1;
  logic stall = 1'b0;
  logic ram_rdy = 1'b1;
  logic sio_idle = 1'b0;
  logic [5:0] row = 6'h00;
  logic [5:0] col = 6'h00;
  logic [31:0] rng = 32'h28cab94f;
  logic [31:0] rs = 32'h28cab94f;
  logic sck, rd_n, wr_n, h_sio, h_en, sio_w, sio_dev, sio_oe_n, two_line, standby;
  logic osc_run, busy, shift_p, incr, ram_vld;
  logic [5:0] ram_addr;
  logic [2:0] lamp;
  logic [1:0] ram_sel;
  logic [7:0] ram_data;
  int miscompares = 0;
  int checked = 0;
  int shifts = 0;
  lscu_pkg::lscu_wr_t exp_q[$];
  lscu_pkg::lscu_wr_t got_q[$];
  // 50 MHz clock
  always #10 clk_i = ~clk_i;
  // Released line shows a changing pattern, never the last value
  assign sio_w = (sio_oe_n === 1'b0) ? sio_dev : (h_en ? h_sio : sio_idle);
  lscu_host host_u (.clk_i(clk_i), .sck_o(sck), .rd_n_o(rd_n), .wr_n_o(wr_n),
    .sio_o(h_sio), .sio_en_o(h_en), .sio_i(sio_w));
  lscu_top #(.EXEC_CYC(EXEC), .QDEPTH(16)) dut_u (.clk_i(clk_i), .rstn_i(rstn_i),
    .sck_i(sck), .rd_strobe_n_i(rd_n), .wr_strobe_n_i(wr_n), .serial_io_line_i(sio_w),
    .serial_io_line_o(sio_dev), .serial_io_line_oe_n_o(sio_oe_n),
    .wake_key_input_n_i(wake_n), .key_down_n_i(key_dn_n), .key_row_bits_i(row),
    .key_col_bits_i(col), .two_line_o(two_line), .standby_o(standby), .osc_run_o(osc_run),
    .busy_flag_o(busy), .shift_pulse_o(shift_p), .incr_dir_o(incr), .lamp_bits_o(lamp),
    .ram_vld_o(ram_vld), .ram_rdy_i(ram_rdy), .ram_sel_o(ram_sel), .ram_addr_o(ram_addr),
    .ram_data_o(ram_data));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  // Expected status word for the pins at load time
  function automatic logic [15:0] st_word(input logic wk, bz, input logic [5:0] r, c);
    return {~wk, bz, r, c, 2'b00};
  endfunction
  // RAM sink stalls at random; the stall flag blocks it fully
  always @(negedge clk_i) begin
    rs <= lfsr(rs);
    ram_rdy <= ~stall & (rs[0] | rs[1]);
    sio_idle <= ~sio_idle;
  end
  // Collect RAM writes and display shift pulses
  always @(posedge clk_i) begin
    if (ram_vld === 1'b1 && ram_rdy === 1'b1) begin
      got_q.push_back({ram_sel, ram_addr, ram_data});
    end
    if (shift_p === 1'b1) begin
      shifts++;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // Busy rises a few cycles after the word, so poll only after a pause
  task automatic wait_idle();
    int n = 0;
    repeat (8) @(negedge clk_i);
    while (busy !== 1'b0 && n < 5000) begin
      @(negedge clk_i);
      n++;
    end
    chk(busy, 1'b0, "busy stuck");
  endtask
  task automatic put(input lscu_pkg::lscu_ram_t s, input logic [5:0] a, input logic [7:0] d);
    exp_q.push_back({s, a, d});
  endtask
  task automatic ram_chk();
    int n = 0;
    while (got_q.size() < exp_q.size() && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    chk(got_q.size(), exp_q.size(), "ram write count");
    foreach (exp_q[i]) begin
      if (i < got_q.size()) chk(got_q[i], exp_q[i], "ram write");
    end
    got_q = {};
    exp_q = {};
  endtask
  // Random key lines, then n status words with the strobe held
  task automatic status_chk(input int n, input logic bz);
    logic [31:0] q;
    logic [15:0] w;
    rng = lfsr(rng);
    row = rng[5:0];
    col = rng[11:6];
    w = st_word(wake_n, bz, rng[5:0], rng[11:6]);
    host_u.rd_words(n, q);
    chk(q, (n == 2) ? {w, w} : {16'h0, w}, "status word");
  endtask
  task automatic conclude();
    if (miscompares == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    logic [5:0] a;
    repeat (16) @(negedge clk_i);
    rstn_i = 1'b1;
    repeat (2) @(negedge clk_i);
    chk({standby, busy, two_line, lamp, incr, sio_oe_n, ram_vld}, 9'h106, "reset");
    wake_n = 1'b0;
    repeat (10) @(negedge clk_i);
    wake_n = 1'b1;
    chk(standby, 1'b0, "wake exit");
    host_u.wr_word(16'h0600, 1'b0);
    wait_idle();
    chk(two_line, 1'b1, "two line mode");
    wake_n = 1'b0;
    status_chk(2, 1'b0);
    wake_n = 1'b1;
    host_u.wr_word(16'h0400, 1'b0);
    wait_idle();
    chk(two_line, 1'b1, "line mode after read");
    // Character burst, incrementing with display shift
    host_u.wr_word(16'h00e0, 1'b0);
    wait_idle();
    chk(incr, 1'b1, "increment");
    rng = lfsr(rng);
    a = {2'h0, rng[3:0]} + 6'h2;
    host_u.wr_word({4'h1, a[4:0], 7'h0}, 1'b0);
    wait_idle();
    host_u.wr_word({8'hc0, rng[15:8]}, 1'b1);
    wait_idle();
    host_u.wr_byte(rng[23:16]);
    wait_idle();
    host_u.wr_end();
    put(lscu_pkg::RAM_CHAR, a, rng[15:8]);
    put(lscu_pkg::RAM_CHAR, a + 6'h1, rng[23:16]);
    ram_chk();
    chk(shifts, 2, "shift pulses");
    // Glyph and icon, decrementing; lamp write lands while busy
    host_u.wr_word(16'h0080, 1'b0);
    wait_idle();
    chk(incr, 1'b0, "decrement");
    rng = lfsr(rng);
    a = rng[5:0] | 6'h1;
    host_u.wr_word({3'h1, a, 7'h0}, 1'b0);
    wait_idle();
    host_u.wr_word({8'hc0, rng[15:8]}, 1'b0);
    wait_idle();
    put(lscu_pkg::RAM_GLYPH, a, {3'h0, rng[12:8]});
    a = {2'h0, rng[19:16] % 4'h9} + 6'h1;
    host_u.wr_word({5'h1, a[3:0], 7'h0}, 1'b0);
    host_u.wr_word({13'h1000, rng[26:24]}, 1'b0);
    wait_idle();
    chk(lamp, rng[26:24], "lamp latch");
    host_u.wr_word({8'hc0, rng[7:0]}, 1'b0);
    wait_idle();
    host_u.wr_word({8'hc0, rng[31:24]}, 1'b0);
    wait_idle();
    put(lscu_pkg::RAM_ICON, a, rng[7:0]);
    put(lscu_pkg::RAM_ICON, a - 6'h1, rng[31:24]);
    ram_chk();
    chk(shifts, 2, "no shift");
    // Second address word arrives while busy and is dropped
    rng = lfsr(rng);
    a = {2'h0, rng[3:0]} + 6'h2;
    host_u.wr_word({4'h1, a[4:0], 7'h0}, 1'b0);
    host_u.wr_word({4'h1, ~a[4:0], 7'h0}, 1'b0);
    status_chk(1, 1'b1);
    wait_idle();
    host_u.wr_word({8'hc0, rng[15:8]}, 1'b0);
    wait_idle();
    put(lscu_pkg::RAM_CHAR, a, rng[15:8]);
    ram_chk();
    // Standby with icon clear; sink stalled so the queue fills
    host_u.wr_word(16'h8015, 1'b0);
    wait_idle();
    stall = 1'b1;
    fork
      host_u.standby(600);
      begin
        repeat (300) @(negedge clk_i);
        wake_n = 1'b0;
        repeat (10) @(negedge clk_i);
        chk({osc_run, standby}, 2'b11, "wake in standby");
        wake_n = 1'b1;
        stall = 1'b0;
        key_dn_n = 1'b0;
        repeat (10) @(negedge clk_i);
        chk(osc_run, 1'b1, "key down keeps osc");
        key_dn_n = 1'b1;
        repeat (10) @(negedge clk_i);
        chk(osc_run, 1'b0, "osc stopped in standby");
      end
    join
    for (int i = 0; i < 20; i++) put(lscu_pkg::RAM_CHAR, i[5:0], 8'h20);
    for (int i = 0; i < 10; i++) put(lscu_pkg::RAM_ICON, i[5:0], 8'h00);
    ram_chk();
    chk(lamp, 3'h5, "lamps kept");
    host_u.wr_word(16'h0001, 1'b0);
    wait_idle();
    chk(standby, 1'b0, "standby clear");
    // Standby again, icon RAM kept this time
    host_u.wr_word(16'h8002, 1'b0);
    wait_idle();
    host_u.standby(100);
    for (int i = 0; i < 20; i++) put(lscu_pkg::RAM_CHAR, i[5:0], 8'h20);
    ram_chk();
    host_u.wr_word(16'h8006, 1'b0);
    wait_idle();
    chk({standby, lamp}, 4'he, "lamp in standby");
    conclude();
  end
  // Watchdog well above the expected run of about 9000 cycles
  initial begin
    repeat (80000) @(posedge clk_i);
    miscompares++;
    conclude();
  end
endmodule
